// *** rtl/dps_pkg.sv ***
// Constants, field positions and types for the disk pack status and write start logic.
// Assumes one 20 MHz controller clock and a synchronous active-high reset.
//
// Function
// (RULE1) Selected unit cylinder readable when idle
// (RULE2) Not-ready bit clears after successful seek
// (RULE3) Seek-underway bit while unit seeks
// (RULE4) Write protect: read-only or lockout match
// (RULE5) Eight attention bits name the unit
// (RULE6) Failed seek raises seek incomplete
// (RULE7) One disk flag, program or priority
// (RULE8) Flag ORs enabled attention and done/error
// (RULE9) Job done on completion or abort
// (RULE10) Error flag ORs all error bits
// (RULE11) Attention flag ORs attention bits
// (RULE12) Attention interrupt enable in bit 7
// (RULE13) Done/error interrupt enable in bit 6
// (RULE14) Software sets counts, addresses, then GO
// (RULE15) Copy counted words, done, stop on error
// (RULE16) Execution begins only when GO sets
// (RULE17) Words enter upper half, shift lower
// (RULE18) Each fetched word bumps count and address
// (RULE19) Cylinder compare seeks toward target
// (RULE20) On arrival select head, read headers
// (RULE21) Busy after loads; busy loads rejected
// (RULE22) All flags update on controller clock
package dps_pkg;

  // ****************************************************************
  // Status register A fields
  // ****************************************************************
  localparam int SA_UNIT_LSB = 0;
  localparam int SA_FUNC_LSB = 3;
  localparam int SA_JDIE = 6;
  localparam int SA_ATIE = 7;
  localparam int SA_GO = 8;
  localparam int SA_WPE = 9;
  localparam int SA_EXT_LSB = 10;
  localparam int SA_WP = 14;
  localparam int SA_SINC = 15;
  localparam int SA_JD = 16;
  localparam int SA_ERR = 17;

  // ****************************************************************
  // Status register B fields
  // ****************************************************************
  localparam int SB_ATTN_LSB = 0;
  localparam int SB_EXT_LSB = 8;
  localparam int SB_PROG = 9;
  localparam int SB_SEEK = 16;
  localparam int SB_NRDY = 17;

  // ****************************************************************
  // Timing and interrupt constants
  // ****************************************************************
  localparam int CLK_NS = 50;
  localparam int BUSY_NS = 4000;
  localparam int BUSY_CYC = (BUSY_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] API_LEVEL = 2'h1;
  // Vector port address, octal 64.
  localparam logic [7:0] API_VECTOR = 8'h34;

  // ****************************************************************
  // Function codes
  // ****************************************************************
  localparam logic [2:0] FN_IDLE = 3'h0;
  localparam logic [2:0] FN_READ = 3'h1;
  localparam logic [2:0] FN_WRITE = 3'h2;
  localparam logic [2:0] FN_WCHK = 3'h3;
  localparam logic [2:0] FN_SEEK = 3'h4;
  localparam logic [2:0] FN_RDALL = 3'h5;
  localparam logic [2:0] FN_WRALL = 3'h6;
  localparam logic [2:0] FN_RECAL = 3'h7;

  // Write transfer sequencer states.
  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_HAND, ST_DONE} dps_state_type;

  // Cylinder positioning states.
  typedef enum logic [1:0] {SK_IDLE, SK_COMP, SK_WAIT, SK_ON} dps_seek_state_type;

endpackage

// *** rtl/dps_seek.sv ***
// Cylinder comparator, seek command and head selection for the selected unit.
// Assumes the drive pulses arrival for one cycle once the heads settle.
`timescale 1ns/1ps
`default_nettype none
module dps_seek import dps_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control
  input wire logic start,
  input wire logic stop,
  input wire logic [7:0] target_cyl,
  input wire logic [7:0] present_cyl,
  input wire logic arrived,
  input wire logic [4:0] head_addr,
  // Drive commands
  output logic seek_cmd,
  output logic seek_dir,
  output logic [7:0] seek_cyl,
  output logic on_cyl,
  output logic [4:0] head_select,
  output logic header_read_en
);

  // ****************************************************************
  // Comparator and state
  // ****************************************************************
  dps_seek_state_type state_reg, state_next;
  wire logic match = (present_cyl == target_cyl);
  wire logic upward = (target_cyl > present_cyl);

  // Next state: compare, seek if needed, wait for arrival, recompare.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SK_IDLE: if (start) state_next = SK_COMP;
      SK_COMP: state_next = match ? SK_ON : SK_WAIT; // RULE19
      SK_WAIT: if (arrived) state_next = SK_COMP; // RULE20
      SK_ON: state_next = SK_ON;
      default: state_next = SK_IDLE;
    endcase
    if (stop) state_next = SK_IDLE;
  end

  // Registered outputs toward the drive.
  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= SK_IDLE;
      seek_cmd <= 1'b0;
      seek_dir <= 1'b0;
      seek_cyl <= 8'h00;
      on_cyl <= 1'b0;
      head_select <= 5'h00;
      header_read_en <= 1'b0;
    end else begin
      state_reg <= state_next;
      seek_cmd <= (state_reg == SK_COMP) && !match && !stop; // RULE19
      if (state_reg == SK_COMP) begin
        seek_dir <= upward;
        seek_cyl <= target_cyl;
      end
      on_cyl <= (state_next == SK_ON);
      if (state_next == SK_ON) head_select <= head_addr; // RULE20
      header_read_en <= (state_next == SK_ON); // RULE20
    end
  end

endmodule
`default_nettype wire

// *** rtl/dps_ctrl.sv ***
// Status facility, interrupt flag and write start sequencer of the disk pack controller.
// Assumes instruction strobes and drive signals are synchronous one-cycle or level inputs.
`timescale 1ns/1ps
`default_nettype none
module dps_ctrl import dps_pkg::*; #(
  parameter int WC_W = 18,
  parameter int ADDR_W = 15,
  parameter int BUSY_COUNT = BUSY_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Instruction strobes and their data
  input wire logic function_load_op,
  input wire logic set_ones_load_op,
  input wire logic zeros_load_op,
  input wire logic continue_op,
  input wire logic [17:0] io_data,
  // Setup register loads
  input wire logic wc_load,
  input wire logic ca_load,
  input wire logic car_load,
  input wire logic head_load,
  // Status readback
  output logic [17:0] status_a_out,
  output logic [17:0] status_b_out,
  output logic [7:0] unit_head_cylinder,
  output logic cyl_read_ok,
  output logic busy_out,
  // Interrupt requests
  input wire logic priority_mode,
  output logic program_interrupt_request,
  output logic priority_interrupt_request,
  output logic [1:0] api_level,
  output logic [7:0] api_vector,
  // Memory fetch
  output logic mem_req,
  output logic [ADDR_W-1:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [17:0] mem_data,
  // Assembled word to the serial writer
  output logic [35:0] buf_word,
  output logic buf_valid,
  input wire logic buf_take,
  // Drive units
  input wire logic [7:0] unit_ready,
  input wire logic [7:0] unit_seeking,
  input wire logic [7:0] unit_read_only,
  input wire logic [7:0] unit_attention,
  input wire logic [7:0] unit_seek_incomplete,
  input wire logic [7:0] sel_cylinder,
  input wire logic lockout_switch,
  input wire logic [2:0] lockout_unit_reg,
  input wire logic [7:0] lockout_cylinder_limit,
  // Error conditions owned elsewhere
  input wire logic [3:0] ext_error_a,
  input wire logic [7:0] ext_error_b,
  // Drive commands
  output logic [2:0] unit_select,
  output logic seek_cmd,
  output logic seek_dir,
  output logic [7:0] seek_cyl,
  output logic [4:0] head_select,
  output logic header_read_en
);

  // ****************************************************************
  // Functions
  // ****************************************************************

  // True for functions that run until job done.
  function automatic logic is_exec(input logic [2:0] fn);
    is_exec = (fn == FN_READ) || (fn == FN_WRITE) || (fn == FN_WCHK) ||
              (fn == FN_RDALL) || (fn == FN_WRALL);
  endfunction

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [8:0] ctl_reg; // Unit, function, enables and GO.
  logic wpe_reg; // Write protect error.
  logic sinc_reg; // Seek incomplete.
  logic jd_reg; // Job done.
  logic prog_reg; // Programming error.
  logic [7:0] attn_reg; // Per-unit attention.
  logic busy_reg; // Controller busy.
  logic exec_busy_reg; // Busy lasts until job done.
  logic [7:0] busy_cnt_reg; // Timed busy counter.
  logic [WC_W-1:0] wc_reg; // Word count, counts up to zero.
  logic [ADDR_W-1:0] ca_reg; // Current memory address.
  logic [7:0] cylinder_address_reg; // Target cylinder.
  logic [4:0] head_addr_reg; // Target head.
  logic [35:0] buf_reg; // Assembly buffer.
  logic half_reg; // Upper half holds a word.
  logic last_reg; // Word count has overflowed.
  dps_state_type state_reg, state_next;

  // ****************************************************************
  // Decode
  // ****************************************************************
  wire logic any_op = function_load_op | set_ones_load_op | zeros_load_op | continue_op;
  wire logic accepted = any_op & ~busy_reg;
  wire logic rejected = any_op & busy_reg;
  wire logic [2:0] sel = ctl_reg[SA_UNIT_LSB +: 3];

  // New control field after an accepted load instruction.
  wire logic [8:0] load_val = io_data[8:0];
  wire logic [8:0] ctl_next = !accepted ? ctl_reg :
                              function_load_op ? load_val :
                              set_ones_load_op ? (ctl_reg | load_val) :
                              zeros_load_op ? (ctl_reg & ~load_val) : ctl_reg;
  wire logic [2:0] fn_new = ctl_next[SA_FUNC_LSB +: 3];
  wire logic [2:0] sel_new = ctl_next[SA_UNIT_LSB +: 3];

  // Start happens only when a load leaves GO set.
  wire logic go_start = accepted & (function_load_op | set_ones_load_op) & ctl_next[SA_GO]; // RULE16
  wire logic exec_go = go_start & is_exec(fn_new);

  // Write protection of the selected unit.
  wire logic lockout_hit = (sel == lockout_unit_reg) && lockout_switch &&
                           (cylinder_address_reg <= lockout_cylinder_limit);
  wire logic wp = unit_read_only[sel] | lockout_hit; // RULE4
  wire logic wp_new = unit_read_only[sel_new] | ((sel_new == lockout_unit_reg) &&
                      lockout_switch && (cylinder_address_reg <= lockout_cylinder_limit));
  wire logic wp_fail = go_start & (fn_new == FN_WRITE) & wp_new;

  // Error and attention summaries.
  wire logic err_any = wpe_reg | (|ext_error_a) | sinc_reg | prog_reg | (|ext_error_b); // RULE10
  wire logic attn_any = |attn_reg; // RULE11
  wire logic flag = (attn_any & ctl_reg[SA_ATIE]) | // RULE12
                    ((jd_reg | err_any) & ctl_reg[SA_JDIE]); // RULE8 RULE13

  // Fetch handshake and last-word detection.
  wire logic fetch_hit = (state_reg == ST_FETCH) & mem_ack;
  wire logic wc_last = &wc_reg;
  wire logic seek_on;

  // Attention set by arrival or failed seek; set wins over clear.
  wire logic [7:0] attn_clr = (accepted & continue_op) ? io_data[7:0] : 8'h00;
  wire logic [7:0] attn_set = unit_attention | unit_seek_incomplete;

  // Assembled status words.
  wire logic [17:0] sa_val = {err_any, jd_reg, sinc_reg, wp, ext_error_a, wpe_reg, ctl_reg};
  wire logic [17:0] sb_val = {~unit_ready[sel], unit_seeking[sel], ext_error_b[7:2],
                              ext_error_b[1] | prog_reg, ext_error_b[0], attn_reg};

  // ****************************************************************
  // Write sequencer
  // ****************************************************************

  // Fetch word pairs, hand each 36-bit word over, stop on overflow or error.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (wp_fail) state_next = ST_DONE; // RULE9
        else if (exec_go && fn_new == FN_WRITE) state_next = ST_FETCH; // RULE15
        else if (exec_go) state_next = ST_DONE;
      end
      ST_FETCH: if (mem_ack && (half_reg || wc_last)) state_next = ST_HAND;
      ST_HAND: begin
        if (buf_take && seek_on) state_next = last_reg ? ST_DONE : ST_FETCH; // RULE15
      end
      ST_DONE: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
    if (err_any && state_reg != ST_IDLE && state_reg != ST_DONE) state_next = ST_DONE; // RULE15
  end

  // Sequencer state.
  always_ff @(posedge clock) begin
    if (rst) state_reg <= ST_IDLE;
    else state_reg <= state_next;
  end

  // Buffer assembly: each word enters the upper half, the older one moves down.
  always_ff @(posedge clock) begin
    if (rst) begin
      buf_reg <= 36'h000000000;
      half_reg <= 1'b0;
    end else if (fetch_hit) begin
      buf_reg[35:18] <= mem_data; // RULE17
      buf_reg[17:0] <= buf_reg[35:18]; // RULE17
      half_reg <= ~half_reg;
    end else if (state_reg == ST_IDLE) begin
      half_reg <= 1'b0;
    end
  end

  // Word count and address step once per fetched word.
  always_ff @(posedge clock) begin
    if (rst) begin
      wc_reg <= '0;
      ca_reg <= '0;
      last_reg <= 1'b0;
    end else begin
      if (wc_load) wc_reg <= io_data[WC_W-1:0];
      else if (fetch_hit) wc_reg <= wc_reg + 1'b1; // RULE18
      if (ca_load) ca_reg <= io_data[ADDR_W-1:0];
      else if (fetch_hit) ca_reg <= ca_reg + 1'b1; // RULE18
      if (fetch_hit) last_reg <= wc_last;
      else if (state_reg == ST_IDLE) last_reg <= 1'b0;
    end
  end

  // Disk address registers loaded by software before GO.
  always_ff @(posedge clock) begin
    if (rst) begin
      cylinder_address_reg <= 8'h00;
      head_addr_reg <= 5'h00;
    end else begin
      if (car_load) cylinder_address_reg <= io_data[7:0];
      if (head_load) head_addr_reg <= io_data[4:0];
    end
  end

  // ****************************************************************
  // Control, flags and busy
  // ****************************************************************

  // Control field; GO drops when the sequencer passes through ST_DONE.
  always_ff @(posedge clock) begin
    if (rst) ctl_reg <= 9'h000;
    else if (state_reg == ST_DONE) ctl_reg <= {1'b0, ctl_next[7:0]};
    else ctl_reg <= ctl_next; // RULE12 RULE13
  end

  // Sticky flags; a set in the same cycle as a clear wins.
  always_ff @(posedge clock) begin
    if (rst) begin
      jd_reg <= 1'b0;
      wpe_reg <= 1'b0;
      sinc_reg <= 1'b0;
      prog_reg <= 1'b0;
      attn_reg <= 8'h00;
    end else begin
      jd_reg <= (state_reg == ST_DONE) | (jd_reg & ~(accepted & (continue_op | function_load_op))); // RULE9
      wpe_reg <= wp_fail | (wpe_reg & ~(accepted & function_load_op));
      sinc_reg <= unit_seek_incomplete[sel] | (sinc_reg & ~(accepted & function_load_op)); // RULE6
      prog_reg <= rejected | (prog_reg & ~(accepted & function_load_op)); // RULE21
      attn_reg <= attn_set | (attn_reg & ~attn_clr); // RULE5 RULE6
    end
  end

  // Busy: timed for initiate functions, until job done for execute ones.
  always_ff @(posedge clock) begin
    if (rst) begin
      busy_reg <= 1'b0;
      exec_busy_reg <= 1'b0;
      busy_cnt_reg <= 8'h00;
    end else if (accepted) begin
      busy_reg <= 1'b1; // RULE21
      exec_busy_reg <= exec_go;
      busy_cnt_reg <= 8'(BUSY_COUNT - 1);
    end else if (exec_busy_reg) begin
      if (state_reg == ST_DONE) begin
        busy_reg <= 1'b0;
        exec_busy_reg <= 1'b0;
      end
    end else if (busy_reg) begin
      if (busy_cnt_reg == 8'h00) busy_reg <= 1'b0;
      else busy_cnt_reg <= busy_cnt_reg - 8'h01;
    end
  end

  // ****************************************************************
  // Cylinder positioning
  // ****************************************************************
  dps_seek u_seek (
    .clock(clock),
    .rst(rst),
    .start(go_start && (fn_new == FN_WRITE || fn_new == FN_SEEK) && !wp_fail),
    .stop(state_reg == ST_DONE),
    .target_cyl(cylinder_address_reg),
    .present_cyl(sel_cylinder),
    .arrived(unit_attention[sel]),
    .head_addr(head_addr_reg),
    .seek_cmd(seek_cmd),
    .seek_dir(seek_dir),
    .seek_cyl(seek_cyl),
    .on_cyl(seek_on),
    .head_select(head_select),
    .header_read_en(header_read_en)
  );

  // ****************************************************************
  // Registered outputs
  // ****************************************************************

  // Every status and request output is a flop of this clock.
  always_ff @(posedge clock) begin
    if (rst) begin
      status_a_out <= 18'h00000;
      status_b_out <= 18'h00000;
      unit_head_cylinder <= 8'h00;
      cyl_read_ok <= 1'b0;
      busy_out <= 1'b0;
      program_interrupt_request <= 1'b0;
      priority_interrupt_request <= 1'b0;
      api_level <= 2'h0;
      api_vector <= 8'h00;
      mem_req <= 1'b0;
      mem_addr <= '0;
      buf_word <= 36'h000000000;
      buf_valid <= 1'b0;
      unit_select <= 3'h0;
    end else begin
      status_a_out <= sa_val; // RULE4 RULE9 RULE10 RULE22
      status_b_out <= sb_val; // RULE2 RULE3 RULE5 RULE22
      unit_head_cylinder <= sel_cylinder; // RULE1
      cyl_read_ok <= ~busy_reg & ~unit_seeking[sel]; // RULE1
      busy_out <= busy_reg;
      program_interrupt_request <= flag & ~priority_mode; // RULE7 RULE22
      priority_interrupt_request <= flag & priority_mode; // RULE7
      api_level <= API_LEVEL; // RULE7
      api_vector <= API_VECTOR; // RULE7
      mem_req <= (state_next == ST_FETCH);
      mem_addr <= (fetch_hit ? ca_reg + 1'b1 : ca_reg);
      buf_word <= (state_next == ST_HAND) ? (fetch_hit ? {mem_data, buf_reg[35:18]} : buf_reg) : buf_word;
      buf_valid <= (state_next == ST_HAND);
      unit_select <= sel;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  prog_err_a: assert property (rejected |=> prog_reg ##1 status_b_out[SB_PROG]) // RULE21
    else $error("busy load did not raise programming error");

  // Timed busy may only end once its counter has run down to zero.
  timed_busy_a: assert property ((accepted && !exec_go) || // RULE21
                                 (busy_reg && !exec_busy_reg && busy_cnt_reg != 8'h00) |=> busy_reg)
    else $error("timed busy ended too early");

  wc_step_a: assert property (fetch_hit && !wc_load |=> wc_reg == $past(wc_reg) + 1'b1) // RULE18
    else $error("word count did not step on fetch");

  buf_shift_a: assert property (fetch_hit |=> buf_reg[17:0] == $past(buf_reg[35:18]) &&
                                buf_reg[35:18] == $past(mem_data)) // RULE17
    else $error("buffer halves not shifted correctly");

  job_done_a: assert property (state_reg == ST_DONE |=> jd_reg ##1 status_a_out[SA_JD]) // RULE9
    else $error("job done not raised after finish");

  go_gate_a: assert property (state_reg == ST_IDLE && !go_start |=> state_reg == ST_IDLE) // RULE16
    else $error("sequencer left idle without GO");

  wp_status_a: assert property (##1 status_a_out[SA_WP] == $past(wp)) // RULE4
    else $error("write protect status wrong");

  attn_set_a: assert property (|unit_attention |=> attn_any ##1 status_b_out[7:0] != 8'h00) // RULE5 RULE11
    else $error("attention not recorded");

  flag_path_a: assert property (attn_any && ctl_reg[SA_ATIE] |=>
                                program_interrupt_request || priority_interrupt_request) // RULE8
    else $error("enabled attention did not request interrupt");

endmodule
`default_nettype wire

// *** verif/dps_far_model.sv ***
// Far side model: memory answering fetches, and the drive bank that seeks.
// Assumes registered controller outputs; its own outputs move at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module dps_far_model (
  // Clock, reset and pacing
  input wire logic clock,
  input wire logic rst,
  input wire logic slow,
  // Memory
  input wire logic mem_req,
  input wire logic [14:0] mem_addr,
  output logic mem_ack,
  output logic [17:0] mem_data,
  // Drive bank
  input wire logic seek_cmd,
  input wire logic [7:0] seek_cyl,
  input wire logic [2:0] unit_select,
  input wire logic buf_valid,
  output logic buf_take,
  output logic [7:0] sel_cylinder,
  output logic [7:0] unit_attention
);
  logic [2:0] move_reg; // Cycles left until the heads settle.
  wire logic give = mem_req && !rst && !(slow && mem_ack); // A slow memory answers every other cycle.
  // ****
  // Behaviour
  // ****
  initial begin
    {mem_ack, buf_take, move_reg} = 5'h00;
    mem_data = 18'h00000;
    sel_cylinder = 8'h10;
    unit_attention = 8'h00;
  end
  // Off-cycle data is the inverse of the previous cycle's value, so no stale word holds steady.
  always @(negedge clock) begin
    mem_ack <= give;
    mem_data <= give ? {3'h5, mem_addr} : ~mem_data;
    buf_take <= buf_valid;
    unit_attention <= 8'h00;
    if (seek_cmd) begin
      move_reg <= 3'h4;
    end else if (move_reg == 3'h1) begin
      // Heads reach the commanded cylinder and the unit raises attention on the same edge.
      sel_cylinder <= seek_cyl;
      unit_attention[unit_select] <= 1'b1;
      move_reg <= 3'h0;
    end else if (move_reg != 3'h0) begin
      move_reg <= move_reg - 3'h1;
    end
  end
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench for the disk pack status and write start controller.
// Assumes dps_ctrl and the far side model; inputs change at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock = 1'b0, rst = 1'b1, priority_mode = 1'b0, slow = 1'b0, lockout_switch = 1'b0;
  logic [7:0] stb = 8'h00, unit_ready = 8'hFF, unit_seeking = 8'h00, unit_read_only = 8'h00;
  logic [7:0] unit_seek_incomplete = 8'h00, ext_error_b = 8'h00, lockout_cylinder_limit = 8'h30;
  logic [3:0] ext_error_a = 4'h0;
  logic [2:0] lockout_unit_reg = 3'h0, unit_select;
  logic [17:0] io_data = 18'h00000, status_a_out, status_b_out, mem_data;
  logic [7:0] unit_head_cylinder, api_vector, sel_cylinder, unit_attention, seek_cyl, got_cyl;
  logic cyl_read_ok, busy_out, program_interrupt_request, priority_interrupt_request, mem_req, mem_ack;
  logic buf_valid, buf_take, seek_cmd, seek_dir, header_read_en, got_dir;
  logic [1:0] api_level;
  logic [14:0] mem_addr, last_addr;
  logic [35:0] buf_word, got_word;
  logic [4:0] head_select, got_head;
  int failures = 0, compares = 0, cycles = 0, n_words = 0;
  // Strobes: 0 function, 1 set ones, 2 zeros, 3 continue, 4 count, 5 address, 6 cylinder, 7 head.
  dps_ctrl #(.BUSY_COUNT(4)) i_dps_ctrl (.clock, .rst, .function_load_op(stb[0]), .set_ones_load_op(stb[1]),
    .zeros_load_op(stb[2]), .continue_op(stb[3]), .io_data, .wc_load(stb[4]), .ca_load(stb[5]),
    .car_load(stb[6]), .head_load(stb[7]), .status_a_out, .status_b_out, .unit_head_cylinder, .cyl_read_ok,
    .busy_out, .priority_mode, .program_interrupt_request, .priority_interrupt_request, .api_level,
    .api_vector, .mem_req, .mem_addr, .mem_ack, .mem_data, .buf_word, .buf_valid, .buf_take, .unit_ready,
    .unit_seeking, .unit_read_only, .unit_attention, .unit_seek_incomplete, .sel_cylinder, .lockout_switch,
    .lockout_unit_reg, .lockout_cylinder_limit, .ext_error_a, .ext_error_b, .unit_select, .seek_cmd,
    .seek_dir, .seek_cyl, .head_select, .header_read_en);
  dps_far_model i_dps_far_model (.clock, .rst, .slow, .mem_req, .mem_addr, .mem_ack, .mem_data, .seek_cmd,
    .seek_cyl, .unit_select, .buf_valid, .buf_take, .sel_cylinder, .unit_attention);
  // ****
  // Clock, watchdog and recorder of transfer events
  // ****
  initial forever #25 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (mem_req && mem_ack) begin
      n_words <= n_words + 1;
      last_addr <= mem_addr;
    end
    if (buf_valid) got_word <= buf_word;
    if (seek_cmd) {got_dir, got_cyl} <= {seek_dir, seek_cyl};
    if (header_read_en) got_head <= head_select;
    if (cycles == 3000) begin
      failures++;
      print_verdict();
    end
  end
  // ****
  // Shared tasks
  // ****
  task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic strobe(input int k, input logic [17:0] d);
    io_data = d;
    stb[k] = 1'b1;
    @(negedge clock);
    stb = 8'h00;
    @(negedge clock);
  endtask
  // Issues an instruction and waits until the controller is no longer busy.
  task automatic op(input int k, input logic [17:0] d);
    strobe(k, d);
    @(negedge clock);
    while (busy_out) @(negedge clock);
  endtask
  task automatic settle;
    repeat (3) @(negedge clock);
  endtask
  task automatic do_reset;
    rst = 1'b1;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    settle();
  endtask
  task automatic print_verdict;
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_reset;
    do_reset();
    chk("status_b", 36'h0, status_b_out);
    chk("api_level", 36'h1, api_level);
    chk("api_vector", 36'h34, api_vector);
  endtask
  // Unit status levels, then lockout at and just above the cylinder limit.
  task automatic t_units;
    {unit_ready, unit_seeking, unit_read_only} = {8'hFE, 8'h01, 8'h01};
    settle();
    chk("not_ready", 36'h1, status_b_out[17]);
    chk("seeking", 36'h1, status_b_out[16]);
    chk("read_ok", 36'h0, cyl_read_ok);
    chk("read_only", 36'h1, status_a_out[14]);
    {unit_ready, unit_seeking, unit_read_only, lockout_switch} = {8'hFF, 8'h00, 8'h00, 1'b1};
    strobe(6, 18'h00030);
    settle();
    chk("ready", 36'h0, status_b_out[17]);
    chk("read_ok", 36'h1, cyl_read_ok);
    chk("cylinder", 36'h10, unit_head_cylinder);
    chk("lockout", 36'h1, status_a_out[14]);
    strobe(6, 18'h00031);
    settle();
    chk("lockout", 36'h0, status_a_out[14]);
    lockout_switch = 1'b0;
  endtask
  // Attention with both enables, priority routing, then masking one enable at a time.
  task automatic t_attn;
    do_reset();
    op(0, 18'h000C0);
    chk("enables", 36'hC0, status_a_out[8:0]);
    unit_seek_incomplete = 8'h01;
    @(negedge clock);
    unit_seek_incomplete = 8'h00;
    settle();
    chk("seek_inc", 36'h1, status_a_out[15]);
    chk("error", 36'h1, status_a_out[17]);
    chk("attn_bits", 36'h01, status_b_out[7:0]);
    chk("prog_req", 36'h1, program_interrupt_request);
    priority_mode = 1'b1;
    settle();
    chk("requests", 36'h2, {priority_interrupt_request, program_interrupt_request});
    priority_mode = 1'b0;
    op(2, 18'h00080);
    chk("err_flag", 36'h1, program_interrupt_request);
    op(2, 18'h00040);
    chk("masked", 36'h0, program_interrupt_request);
    op(3, 18'h000FF);
    chk("attn_bits", 36'h00, status_b_out[7:0]);
    op(1, 18'h00080);
    chk("attn_flag", 36'h0, program_interrupt_request);
  endtask
  // A load inside the busy time is refused and flagged; outside errors show in their status fields, and the error flag clears once they drop.
  task automatic t_prog;
    do_reset();
    strobe(0, 18'h00020);
    strobe(0, 18'h00038);
    while (busy_out) @(negedge clock);
    chk("function", 36'h4, status_a_out[5:3]);
    chk("prog_err", 36'h1, status_b_out[9]);
    chk("error", 36'h1, status_a_out[17]);
    {ext_error_a, ext_error_b} = {4'h2, 8'h10};
    op(0, 18'h00000);
    chk("ext_a", 36'h2, status_a_out[13:10]);
    chk("ext_b", 36'h10, status_b_out[15:8]);
    {ext_error_a, ext_error_b} = {4'h0, 8'h00};
    settle();
    chk("error", 36'h0, status_a_out[17]);
  endtask
  // Two-word write to unit 1 with a slow memory, loaded first with GO clear.
  task automatic t_write;
    do_reset();
    slow = 1'b1;
    strobe(4, 18'h3FFFE);
    strobe(5, 18'h00020);
    strobe(6, 18'h00020);
    strobe(7, 18'h00005);
    op(0, 18'h00051);
    chk("no_fetch", 36'h0, mem_req);
    op(1, 18'h00100);
    chk("job_done", 36'h1, status_a_out[16]);
    chk("prog_req", 36'h1, program_interrupt_request);
    chk("words", 36'h2, n_words);
    chk("last_addr", 36'h21, last_addr);
    chk("buffer", {3'h5, 15'h0021, 3'h5, 15'h0020}, got_word);
    chk("seek", 36'h120, {got_dir, got_cyl});
    chk("head", 36'h05, got_head);
  endtask
  initial begin
    t_reset();
    t_units();
    t_attn();
    t_prog();
    t_write();
    print_verdict();
  end
endmodule
`default_nettype wire
